//--- agc_rx_cfg.svh
`ifndef AGC_RX_CFG_SVH
`define AGC_RX_CFG_SVH

// Register offsets (byte addresses on the serial configuration port)
`define OFS_AGC_CONFIG_0 8'h33
`define OFS_AGC_CONFIG_1 8'h34
`define OFS_AGC_THRESHOLDS 8'h35
`define OFS_DIGITAL_RECEIVER_CONFIG 8'h36
`define OFS_RSSI_PEAK_START_DELAY 8'h37

// Reset values
`define RST_AGC_CONFIG_0 8'h2b
`define RST_AGC_CONFIG_1 8'h03
`define RST_AGC_THRESHOLDS 8'h08
`define RST_DIGITAL_RECEIVER_CONFIG 8'h40
`define RST_RSSI_PEAK_START_DELAY 8'h00

// Writable bit masks; everything else reads zero
`define MASK_AGC_CONFIG_0 8'h7f
`define MASK_AGC_CONFIG_1 8'h03
`define MASK_FULL 8'hff

// Field positions
`define POS_RSSI_GAIN_CORR 4
`define POS_HYSTERESIS 2
`define POS_GAIN_SELECT 0
`define POS_UPPER_STEP 4
`define POS_LOWER_STEP 0
`define POS_RX_REINIT 7
`define POS_FRAMER_REINIT 6
`define POS_LINE_CODE 4
`define POS_CHIP_INVERT 3
`define POS_EXT_INVERT 2
`define POS_AAF_BYPASS 1
`define POS_AAF_CORNER 0

// Thresholds and gain correction in units of 0.1 dB
`define UPPER_BASE_TENTH_DB 10'h100
`define STEP_TENTH_DB 10'h010
`define GAIN_CORR_BASE_TENTH_DB 8'h91
`define GAIN_CORR_STEP_TENTH_DB 8'h05

// Fixed peak detector latencies after the programmed delay, in bit periods
`define PEAK_LATENCY_T1 4'h2
`define PEAK_LATENCY_T2 4'h1

`endif

//--- agc_rx_pkg.sv
package agc_rx_pkg;

  typedef enum logic [1:0] {
    GAIN_ZERO_DB = 2'h0,
    GAIN_MINUS_15_DB = 2'h1,
    GAIN_MINUS_30_DB = 2'h2,
    GAIN_AUTOMATIC = 2'h3
  } gain_mode_type;

  typedef enum logic [1:0] {
    CODE_MANCHESTER = 2'h0,
    CODE_DIFF_MANCHESTER = 2'h1,
    CODE_BIPHASE_SPACE = 2'h2,
    CODE_BIPHASE_MARK = 2'h3
  } line_code_type;

  typedef struct packed {
    logic [2:0] rssiGainCorrection;
    logic [1:0] gainThresholdHysteresis;
    gain_mode_type gainControlSelect;
    logic [1:0] gainThresholdOffset;
    logic [3:0] upperAttackStep;
    logic [3:0] lowerAttackStep;
  } agc_cfg_type;

  typedef struct packed {
    logic rxReinitOnEnd;
    logic framerReinitOnCycle;
    line_code_type lineCode;
    logic chipDataInvert;
    logic externalDataInvert;
    logic antialiasBypass;
    logic antialiasCornerSelect;
  } rx_cfg_type;

  typedef struct packed {
    // Upper sum reaches 113.5 dB, one bit more than the lower threshold and hysteresis
    logic [10:0] upperThreshold;
    logic [9:0] lowerThreshold;
    logic [9:0] hysteresis;
    logic [7:0] rssiGainCorrection;
    logic [5:0] fixedGainAtten;
    logic automaticGain;
  } agc_derived_type;

endpackage

//--- peak_capture_timer.sv
`timescale 1ns/1ps
`include "agc_rx_cfg.svh"

module peak_capture_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Receiver timing
  input wire logic frameSync,
  input wire logic bitStrobe,
  input wire logic rxReinit,
  input wire logic [7:0] peakCaptureDelay,
  // Capture window
  output logic captureEnable
);

  logic [8:0] count_q;
  logic armed_q;
  logic [8:0] target;

  // Programmed bit delay plus the fixed filter and computation latencies
  assign target = {1'b0, peakCaptureDelay} + {5'h00, `PEAK_LATENCY_T1} + {5'h00, `PEAK_LATENCY_T2};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      armed_q <= 1'b0;
      count_q <= 9'h000;
    end else if (rxReinit) begin
      armed_q <= 1'b0;
      count_q <= 9'h000;
    end else if (frameSync) begin
      armed_q <= 1'b1;
      count_q <= 9'h000;
    end else if (armed_q && bitStrobe && count_q != target) begin
      count_q <= count_q + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      captureEnable <= 1'b0;
    end else begin
      captureEnable <= armed_q && !frameSync && !rxReinit && count_q == target;
    end
  end

endmodule

//--- agc_rx_config.sv
// Functional notes
// - Gain correction 14.5 to 18.0 dB, reset 2
// - Hysteresis 12.8/17.1/21.3/25.6 dB, reset 2
// - Threshold offset 25.5 to 63.9 dB, reset 3
// - Upper threshold: offset plus 25.6 plus 1.6*step
// - Lower threshold: offset plus 1.6*step, reset 8
// - Reinit receiver at end or sync loss
// - Reinit framer at polling cycle start
// - Line code selects decoder, reset Manchester
// - Invert chip data for output and decoder
// - Invert external data and matched-filter data
// - Anti-alias bypass and 40/80 kHz corner
// - Peak capture delayed 0 to 255 bits
// - Add fixed latencies to capture start
`timescale 1ns/1ps
`include "agc_rx_cfg.svh"

module agc_rx_config (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration port
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  output logic [7:0] cfgRdata,
  output logic cfgHit,
  // Receiver events
  input wire logic endOfMessage,
  input wire logic symbolSyncLost,
  input wire logic cycleStart,
  input wire logic runModeSelfPolling,
  input wire logic frameSync,
  input wire logic bitStrobe,
  // Baseband data
  input wire logic chipDataRaw,
  input wire logic dataRaw,
  input wire logic matchedFilterDataRaw,
  output logic chipDataOut,
  output logic decoderData,
  output logic dataOut,
  output logic matchedFilterDataOut,
  // Configuration to the datapath
  output agc_rx_pkg::agc_cfg_type agcCfg,
  output agc_rx_pkg::rx_cfg_type rxCfg,
  output agc_rx_pkg::agc_derived_type agcDerived,
  output logic rxReinit,
  output logic framerReinit,
  output logic wakeUpDataInSearch,
  output logic peakCaptureEnable
);

  logic [7:0] agcConfig0_q;
  logic [7:0] agcConfig1_q;
  logic [7:0] agcThresholds_q;
  logic [7:0] rxConfig_q;
  logic [7:0] peakDelay_q;
  logic [9:0] offsetTenths;
  logic [7:0] readData_d;
  logic readHit_d;

  // Writes land only in defined bits, so unused bits stay zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      agcConfig0_q <= `RST_AGC_CONFIG_0;
    end else if (cfgWrite && cfgAddr == `OFS_AGC_CONFIG_0) begin
      agcConfig0_q <= cfgWdata & `MASK_AGC_CONFIG_0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      agcConfig1_q <= `RST_AGC_CONFIG_1;
    end else if (cfgWrite && cfgAddr == `OFS_AGC_CONFIG_1) begin
      agcConfig1_q <= cfgWdata & `MASK_AGC_CONFIG_1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      agcThresholds_q <= `RST_AGC_THRESHOLDS;
    end else if (cfgWrite && cfgAddr == `OFS_AGC_THRESHOLDS) begin
      agcThresholds_q <= cfgWdata & `MASK_FULL;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxConfig_q <= `RST_DIGITAL_RECEIVER_CONFIG;
    end else if (cfgWrite && cfgAddr == `OFS_DIGITAL_RECEIVER_CONFIG) begin
      rxConfig_q <= cfgWdata & `MASK_FULL;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      peakDelay_q <= `RST_RSSI_PEAK_START_DELAY;
    end else if (cfgWrite && cfgAddr == `OFS_RSSI_PEAK_START_DELAY) begin
      peakDelay_q <= cfgWdata & `MASK_FULL;
    end
  end

  // Read mux; unmapped addresses answer zero with no hit
  always_comb begin
    readData_d = 8'h00;
    readHit_d = 1'b1;
    case (cfgAddr)
      `OFS_AGC_CONFIG_0: readData_d = agcConfig0_q & `MASK_AGC_CONFIG_0;
      `OFS_AGC_CONFIG_1: readData_d = agcConfig1_q & `MASK_AGC_CONFIG_1;
      `OFS_AGC_THRESHOLDS: readData_d = agcThresholds_q;
      `OFS_DIGITAL_RECEIVER_CONFIG: readData_d = rxConfig_q;
      `OFS_RSSI_PEAK_START_DELAY: readData_d = peakDelay_q;
      default: readHit_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfgRdata <= 8'h00;
      cfgHit <= 1'b0;
    end else if (cfgRead) begin
      cfgRdata <= readData_d;
      cfgHit <= readHit_d;
    end else begin
      cfgHit <= 1'b0;
    end
  end

  // Field unpacking
  always_comb begin
    agcCfg.rssiGainCorrection = agcConfig0_q[`POS_RSSI_GAIN_CORR +: 3];
    agcCfg.gainThresholdHysteresis = agcConfig0_q[`POS_HYSTERESIS +: 2];
    agcCfg.gainControlSelect = agc_rx_pkg::gain_mode_type'(agcConfig0_q[`POS_GAIN_SELECT +: 2]);
    agcCfg.gainThresholdOffset = agcConfig1_q[1:0];
    agcCfg.upperAttackStep = agcThresholds_q[`POS_UPPER_STEP +: 4];
    agcCfg.lowerAttackStep = agcThresholds_q[`POS_LOWER_STEP +: 4];
  end

  always_comb begin
    rxCfg.rxReinitOnEnd = rxConfig_q[`POS_RX_REINIT];
    rxCfg.framerReinitOnCycle = rxConfig_q[`POS_FRAMER_REINIT];
    rxCfg.lineCode = agc_rx_pkg::line_code_type'(rxConfig_q[`POS_LINE_CODE +: 2]);
    rxCfg.chipDataInvert = rxConfig_q[`POS_CHIP_INVERT];
    rxCfg.externalDataInvert = rxConfig_q[`POS_EXT_INVERT];
    rxCfg.antialiasBypass = rxConfig_q[`POS_AAF_BYPASS];
    rxCfg.antialiasCornerSelect = rxConfig_q[`POS_AAF_CORNER];
  end

  // Threshold offset table in tenths of a dB
  always_comb begin
    case (agcCfg.gainThresholdOffset)
      2'h0: offsetTenths = 10'h0ff;
      2'h1: offsetTenths = 10'h17f;
      2'h2: offsetTenths = 10'h1ff;
      2'h3: offsetTenths = 10'h27f;
      default: offsetTenths = 10'h0ff;
    endcase
  end

  // Derived values kept in flip-flops; tenths of a dB avoid fractional math
  always_ff @(posedge clk) begin
    if (!nrst) begin
      agcDerived <= '0;
    end else begin
      agcDerived.upperThreshold <= 11'(offsetTenths) + 11'(`UPPER_BASE_TENTH_DB)
        + 11'(agcCfg.upperAttackStep * `STEP_TENTH_DB);
      agcDerived.lowerThreshold <= offsetTenths + 10'(agcCfg.lowerAttackStep * `STEP_TENTH_DB);
      agcDerived.rssiGainCorrection <= `GAIN_CORR_BASE_TENTH_DB
        + 8'(agcCfg.rssiGainCorrection * `GAIN_CORR_STEP_TENTH_DB);
      case (agcCfg.gainThresholdHysteresis)
        2'h0: agcDerived.hysteresis <= 10'h080;
        2'h1: agcDerived.hysteresis <= 10'h0ab;
        2'h2: agcDerived.hysteresis <= 10'h0d5;
        default: agcDerived.hysteresis <= 10'h100;
      endcase
      case (agcCfg.gainControlSelect)
        agc_rx_pkg::GAIN_ZERO_DB: begin
          agcDerived.fixedGainAtten <= 6'h00;
          agcDerived.automaticGain <= 1'b0;
        end
        agc_rx_pkg::GAIN_MINUS_15_DB: begin
          agcDerived.fixedGainAtten <= 6'h0f;
          agcDerived.automaticGain <= 1'b0;
        end
        agc_rx_pkg::GAIN_MINUS_30_DB: begin
          agcDerived.fixedGainAtten <= 6'h1e;
          agcDerived.automaticGain <= 1'b0;
        end
        default: begin
          agcDerived.fixedGainAtten <= 6'h00;
          agcDerived.automaticGain <= 1'b1;
        end
      endcase
    end
  end

  // Reinit strobes are registered; each follows its gated triggering event one cycle later, for as long as it lasts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxReinit <= 1'b0;
      framerReinit <= 1'b0;
    end else begin
      rxReinit <= rxCfg.rxReinitOnEnd && (endOfMessage || symbolSyncLost);
      framerReinit <= rxCfg.framerReinitOnCycle && runModeSelfPolling && cycleStart;
    end
  end

  assign wakeUpDataInSearch = !rxCfg.framerReinitOnCycle;

  // Registered data paths; one cycle of latency on all four
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chipDataOut <= 1'b0;
      decoderData <= 1'b0;
      dataOut <= 1'b0;
      matchedFilterDataOut <= 1'b0;
    end else begin
      chipDataOut <= chipDataRaw ^ rxCfg.chipDataInvert;
      decoderData <= chipDataRaw ^ rxCfg.chipDataInvert;
      dataOut <= dataRaw ^ rxCfg.externalDataInvert;
      matchedFilterDataOut <= matchedFilterDataRaw ^ rxCfg.externalDataInvert;
    end
  end

  peak_capture_timer peakTimer (
    .clk(clk),
    .nrst(nrst),
    .frameSync(frameSync),
    .bitStrobe(bitStrobe),
    .rxReinit(rxReinit),
    .peakCaptureDelay(peakDelay_q),
    .captureEnable(peakCaptureEnable)
  );

endmodule

//--- agc_rx_config_chk.sv
`timescale 1ns/1ps
module agc_rx_config_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgRdata,
  input wire logic cfgHit,
  // Events and data
  input wire logic endOfMessage,
  input wire logic symbolSyncLost,
  input wire logic cycleStart,
  input wire logic runModeSelfPolling,
  input wire logic frameSync,
  input wire logic chipDataRaw,
  input wire logic dataRaw,
  input wire logic matchedFilterDataRaw,
  input wire logic chipDataOut,
  input wire logic decoderData,
  input wire logic dataOut,
  input wire logic matchedFilterDataOut,
  // Configuration outputs
  input wire agc_rx_pkg::agc_cfg_type agcCfg,
  input wire agc_rx_pkg::rx_cfg_type rxCfg,
  input wire agc_rx_pkg::agc_derived_type agcDerived,
  input wire logic rxReinit,
  input wire logic framerReinit,
  input wire logic wakeUpDataInSearch,
  input wire logic peakCaptureEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_read_hit: assert property (cfgRead && cfgAddr inside {[8'h33:8'h37]} |=> cfgHit)
    else $error("no hit on mapped read");
  a_unmapped_read: assert property (cfgRead && !(cfgAddr inside {[8'h33:8'h37]}) |=> !cfgHit && cfgRdata == 8'h00)
    else $error("unmapped read answered");
  a_rx_reinit: assert property ($past(nrst) |-> rxReinit == $past(rxCfg.rxReinitOnEnd && (endOfMessage || symbolSyncLost)))
    else $error("receiver reinit wrong");
  a_framer_reinit: assert property ($past(nrst) |->
    framerReinit == $past(rxCfg.framerReinitOnCycle && runModeSelfPolling && cycleStart))
    else $error("framer reinit wrong");
  a_wake_search: assert property (wakeUpDataInSearch == !rxCfg.framerReinitOnCycle)
    else $error("wake-up search level wrong");
  a_chip_invert: assert property ($past(nrst) |->
    chipDataOut == $past(chipDataRaw ^ rxCfg.chipDataInvert) && decoderData == chipDataOut)
    else $error("chip data inversion wrong");
  a_ext_invert: assert property ($past(nrst) |->
    dataOut == $past(dataRaw ^ rxCfg.externalDataInvert)
    && matchedFilterDataOut == $past(matchedFilterDataRaw ^ rxCfg.externalDataInvert))
    else $error("external data inversion wrong");
  a_lower_thresh: assert property ($past(nrst, 2) |->
    {1'b0, agcDerived.lowerThreshold} ==
    $past(11'h0ff + 11'h080 * agcCfg.gainThresholdOffset + 11'h010 * agcCfg.lowerAttackStep))
    else $error("lower threshold wrong");
  a_upper_thresh: assert property ($past(nrst, 2) |->
    agcDerived.upperThreshold ==
    $past(11'h1ff + 11'h080 * agcCfg.gainThresholdOffset + 11'h010 * agcCfg.upperAttackStep))
    else $error("upper threshold wrong");
  a_peak_restart: assert property (frameSync |=> !peakCaptureEnable)
    else $error("capture open right after frame sync");
endmodule

bind agc_rx_config agc_rx_config_chk i_chk (.clk(clk), .nrst(nrst), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
  .cfgRdata(cfgRdata), .cfgHit(cfgHit), .endOfMessage(endOfMessage), .symbolSyncLost(symbolSyncLost),
  .cycleStart(cycleStart), .runModeSelfPolling(runModeSelfPolling), .frameSync(frameSync),
  .chipDataRaw(chipDataRaw), .dataRaw(dataRaw), .matchedFilterDataRaw(matchedFilterDataRaw),
  .chipDataOut(chipDataOut), .decoderData(decoderData), .dataOut(dataOut),
  .matchedFilterDataOut(matchedFilterDataOut), .agcCfg(agcCfg), .rxCfg(rxCfg), .agcDerived(agcDerived),
  .rxReinit(rxReinit), .framerReinit(framerReinit), .wakeUpDataInSearch(wakeUpDataInSearch),
  .peakCaptureEnable(peakCaptureEnable));

//--- agc_rx_config_bench.sv
`timescale 1ns/1ps
module agc_rx_config_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfgWrite = 1'b0;
  logic cfgRead = 1'b0;
  logic runModeSelfPolling = 1'b0;
  logic chipDataRaw = 1'b0;
  logic dataRaw = 1'b0;
  logic matchedFilterDataRaw = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [7:0] cfgAddr = 8'h00;
  logic [7:0] cfgWdata = 8'h00;
  logic [7:0] cfgRdata;
  logic cfgHit, chipDataOut, decoderData, dataOut, matchedFilterDataOut;
  logic rxReinit, framerReinit, wakeUpDataInSearch, peakCaptureEnable;
  agc_rx_pkg::agc_cfg_type agcCfg;
  agc_rx_pkg::rx_cfg_type rxCfg;
  agc_rx_pkg::agc_derived_type agcDerived;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  // Row: address, written, read back, hit
  logic [24:0] rows [7] = '{{8'h33, 8'hff, 8'h7f, 1'b1}, {8'h34, 8'hff, 8'h03, 1'b1}, {8'h35, 8'ha5, 8'ha5, 1'b1},
    {8'h36, 8'h8c, 8'h8c, 1'b1}, {8'h37, 8'hff, 8'hff, 1'b1}, {8'h38, 8'h55, 8'h00, 1'b0}, {8'h32, 8'h11, 8'h00, 1'b0}};
  logic [7:0] rstVal [5] = '{8'h2b, 8'h03, 8'h08, 8'h40, 8'h00};
  logic [15:0] hys [4] = '{16'h0080, 16'h00ab, 16'h00d5, 16'h0100};
  logic [15:0] atten [4] = '{16'h0000, 16'h000f, 16'h001e, 16'h0000};

  always #2 clk = ~clk;

  agc_rx_config i_dut (.clk(clk), .nrst(nrst), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgHit(cfgHit), .endOfMessage(ev[0]), .symbolSyncLost(ev[1]),
    .cycleStart(ev[2]), .runModeSelfPolling(runModeSelfPolling), .frameSync(ev[3]), .bitStrobe(ev[4]),
    .chipDataRaw(chipDataRaw), .dataRaw(dataRaw), .matchedFilterDataRaw(matchedFilterDataRaw),
    .chipDataOut(chipDataOut), .decoderData(decoderData), .dataOut(dataOut),
    .matchedFilterDataOut(matchedFilterDataOut), .agcCfg(agcCfg), .rxCfg(rxCfg), .agcDerived(agcDerived),
    .rxReinit(rxReinit), .framerReinit(framerReinit), .wakeUpDataInSearch(wakeUpDataInSearch),
    .peakCaptureEnable(peakCaptureEnable));

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgWdata <= d;
    @(posedge clk);
    cfgWrite <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'b0;
    @(negedge clk);
    check(cfgRdata, e);
    check(cfgHit, h);
  endtask

  // Event pulse lasts one cycle; result looked at half a cycle after it is taken
  task pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
    @(negedge clk);
  endtask

  task settle;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
  endtask

  task reset_values;
    for (int i = 0; i < 5; i++)
      rd(8'h33 + 8'(i), rstVal[i], 1'b1);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    logic b, v;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][24:17], rows[i][16:9]);
      rd(rows[i][24:17], rows[i][8:1], rows[i][0]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h33, {1'b0, 3'(2 * i + 1), 2'(i), 2'(i)});
      wr(8'h36, {2'h0, 2'(i), 4'h0});
      settle();
      check(rxCfg.lineCode, 16'(i));
      check(agcDerived.hysteresis, hys[i]);
      check(agcDerived.rssiGainCorrection, 16'h0096 + 16'(10 * i));
      check(agcDerived.fixedGainAtten, atten[i]);
      check(agcDerived.automaticGain, 16'(i == 3));
    end
    wr(8'h34, 8'h03);
    wr(8'h35, 8'hf9);
    settle();
    check(agcDerived.upperThreshold, 16'h046f);
    check(agcCfg, 32'h0001fff9);
    check(agcDerived.lowerThreshold, 16'h030f);
    wr(8'h34, 8'h00);
    settle();
    check(agcDerived.upperThreshold, 16'h02ef);
    check(agcDerived.lowerThreshold, 16'h018f);
    for (int j = 0; j < 4; j++) begin
      b = j[0];
      v = j[1];
      wr(8'h36, v ? 8'h0c : 8'h03);
      @(posedge clk);
      chipDataRaw <= b;
      dataRaw <= !b;
      matchedFilterDataRaw <= b;
      @(posedge clk);
      @(negedge clk);
      check(chipDataOut, b ^ v);
      check(decoderData, b ^ v);
      check(dataOut, !b ^ v);
      check(matchedFilterDataOut, b ^ v);
      check({rxCfg.antialiasBypass, rxCfg.antialiasCornerSelect}, v ? 16'h0000 : 16'h0003);
    end
    wr(8'h36, 8'h00);
    runModeSelfPolling <= 1'b1;
    pulse(5'h07);
    check({rxReinit, framerReinit, wakeUpDataInSearch}, 16'h0001);
    wr(8'h36, 8'hc0);
    pulse(5'h02);
    check({rxReinit, framerReinit, wakeUpDataInSearch}, 16'h0004);
    check(rxCfg, 16'h00c0);
    pulse(5'h04);
    check({rxReinit, framerReinit, wakeUpDataInSearch}, 16'h0002);
    pulse(5'h01);
    check(rxReinit, 16'h0001);
    @(posedge clk);
    runModeSelfPolling <= 1'b0;
    pulse(5'h04);
    check({rxReinit, framerReinit, wakeUpDataInSearch}, 16'h0000);
    wr(8'h37, 8'h01);
    pulse(5'h08);
    // Delay 1 plus fixed latencies of 3 bits: opens after the fourth bit
    for (int k = 0; k < 4; k++) begin
      pulse(5'h10);
      @(negedge clk);
      check(peakCaptureEnable, 16'(k == 3));
    end
    pulse(5'h08);
    check(peakCaptureEnable, 16'h0000);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    check(agcCfg, 32'h0000af08);
    check(agcDerived.upperThreshold, 16'h037f);
    check(agcDerived.lowerThreshold, 16'h02ff);
    finish_test();
  end
endmodule
